// file: common/lbsc_cfg_if.sv
// carries decoded configuration writes from the serial engine to the register store
`timescale 1ns/1ps
interface lbsc_cfg_if;
  logic       wr_stb;
  logic [7:0] wr_byte;
  logic [1:0] run_cfg;
  logic [1:0] stby_cfg;
  logic [4:0] dac_code;
  modport engine (output wr_stb, output wr_byte, input run_cfg, input stby_cfg, input dac_code);
  modport store  (input wr_stb, input wr_byte, output run_cfg, output stby_cfg, output dac_code);
endinterface

// file: common/lbsc_pkg.sv
// constants and types shared by the lcd bias serial control block
package lbsc_pkg;
  localparam logic [6:0] LBSC_SLAVE_ADDR    = 7'h2C;
  localparam int         LBSC_SEL_BIT       = 7;
  localparam int         LBSC_SHUTDOWN_N_PIN_BIT      = 6;
  localparam int         LBSC_PANEL_BIT     = 5;
  localparam int         LBSC_DAC_MSB       = 4;
  localparam logic [1:0] LBSC_RUN_RESET     = 2'h3;
  localparam logic [1:0] LBSC_STBY_RESET    = 2'h0;
  localparam logic [4:0] LBSC_DAC_RESET     = 5'h10;
  localparam logic [1:0] LBSC_RSVD_BITS     = 2'h0;
  localparam int         LBSC_DAC_LEVELS    = 32;

  typedef enum logic [2:0] {
    LBSC_IDLE,
    LBSC_ADDR,
    LBSC_ADDR_ACK,
    LBSC_WDATA,
    LBSC_WACK,
    LBSC_RDATA,
    LBSC_RACK
  } lbsc_state_t;
endpackage

// file: rtl/lbsc_cfg_store.sv
// configuration and dac code registers loaded from written bytes
`timescale 1ns/1ps
module lbsc_cfg_store
  import lbsc_pkg::*;
(
  // clock and reset
  input  wire logic core_clk_in,
  input  wire logic rstn_in,
  // write side
  lbsc_cfg_if.store cfg
);
  logic [1:0] run_q;
  logic [1:0] stby_q;
  logic [4:0] dac_q;

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      run_q  <= LBSC_RUN_RESET;
      stby_q <= LBSC_STBY_RESET;
    end else if (cfg.wr_stb) begin
      if (cfg.wr_byte[LBSC_SEL_BIT]) begin
        run_q <= cfg.wr_byte[LBSC_SHUTDOWN_N_PIN_BIT:LBSC_PANEL_BIT];
      end else begin
        stby_q <= cfg.wr_byte[LBSC_SHUTDOWN_N_PIN_BIT:LBSC_PANEL_BIT];
      end
    end
  end

  // every write loads the code, whatever the select bit
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      dac_q <= LBSC_DAC_RESET;
    end else if (cfg.wr_stb) begin
      dac_q <= cfg.wr_byte[LBSC_DAC_MSB:0];
    end
  end

  assign cfg.run_cfg  = run_q;
  assign cfg.stby_cfg = stby_q;
  assign cfg.dac_code = dac_q;

  a_dac_load: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    cfg.wr_stb |=> dac_q == $past(cfg.wr_byte[LBSC_DAC_MSB:0]))
    else $error("dac code not loaded from written byte");
  a_run_select: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (cfg.wr_stb && !cfg.wr_byte[LBSC_SEL_BIT]) |=> $stable(run_q))
    else $error("run config changed on standby write");
endmodule

// file: rtl/lbsc_top.sv
// lcd bias serial control: smbus slave, config registers, status and panel switch
`timescale 1ns/1ps
module lbsc_top
  import lbsc_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rstn_in,
  // smbus pins
  input  wire logic       smb_scl_in,
  input  wire logic       smb_sda_in,
  output logic            smb_sda_out,
  output logic            smb_sda_oe_out,
  // analog side
  input  wire logic       low_power_select_pin_in,
  input  wire logic       power_good_sense_in,
  output logic            panel_switch_n_out,
  output logic            panel_switch_n_oe_out,
  output logic            shutdown_n_pin_out,
  output logic [4:0]      dac_code_out
);
  lbsc_cfg_if cfg ();

  lbsc_cfg_store u_store (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .cfg         (cfg)
  );

  // two-stage synchronisers; stage one read only by stage two
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic [1:0] sel_sync_q;
  logic [1:0] pg_sync_q;
  logic       scl_prev_q;
  logic       sda_prev_q;

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      // run side first, so shutdown does not blink low while the pin is still in flight
      sel_sync_q <= 2'h3;
      pg_sync_q  <= 2'h0;
      scl_prev_q <= 1'h1;
      sda_prev_q <= 1'h1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], smb_scl_in};
      sda_sync_q <= {sda_sync_q[0], smb_sda_in};
      sel_sync_q <= {sel_sync_q[0], low_power_select_pin_in};
      pg_sync_q  <= {pg_sync_q[0], power_good_sense_in};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_s    = scl_sync_q[1];
  assign sda_s    = sda_sync_q[1];
  assign scl_rise = scl_s && !scl_prev_q;
  assign scl_fall = !scl_s && scl_prev_q;
  assign start_ev = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  assign stop_ev  = scl_s && scl_prev_q && !sda_prev_q && sda_s;

  // active configuration and derived status
  logic [1:0] active_cfg;
  logic       running;
  logic       panel_en;
  logic       pg_s;
  logic [7:0] status_byte;
  assign active_cfg = sel_sync_q[1] ? cfg.run_cfg : cfg.stby_cfg;
  assign running    = active_cfg[1];
  assign panel_en   = active_cfg[0];
  assign pg_s       = pg_sync_q[1];
  assign status_byte = {pg_s && running, LBSC_RSVD_BITS, cfg.dac_code};

  // serial engine; never gated by shutdown so the host can wake the part
  lbsc_state_t state_q;
  logic [7:0]  shift_q;
  logic [3:0]  bit_cnt_q;
  logic        is_read_q;
  logic        sda_low_q;
  logic        wr_stb_q;
  logic        data_done_q;

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      state_q     <= LBSC_IDLE;
      shift_q     <= 8'h00;
      bit_cnt_q   <= 4'h0;
      is_read_q   <= 1'b0;
      sda_low_q   <= 1'b0;
      wr_stb_q    <= 1'b0;
      data_done_q <= 1'b0;
    end else begin
      wr_stb_q <= 1'b0;
      if (start_ev) begin
        state_q     <= LBSC_ADDR;
        bit_cnt_q   <= 4'h0;
        sda_low_q   <= 1'b0;
        data_done_q <= 1'b0;
      end else if (stop_ev) begin
        state_q   <= LBSC_IDLE;
        sda_low_q <= 1'b0;
      end else begin
        unique case (state_q)
          LBSC_IDLE: begin
            sda_low_q <= 1'b0;
          end
          LBSC_ADDR: begin
            if (scl_rise) begin
              shift_q   <= {shift_q[6:0], sda_s};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && bit_cnt_q == 4'h8) begin
              if (shift_q[7:1] == LBSC_SLAVE_ADDR) begin
                is_read_q <= shift_q[0];
                sda_low_q <= 1'b1;
                state_q   <= LBSC_ADDR_ACK;
              end else begin
                state_q <= LBSC_IDLE;
              end
            end
          end
          LBSC_ADDR_ACK: begin
            if (scl_fall) begin
              bit_cnt_q <= 4'h0;
              if (is_read_q) begin
                shift_q   <= {status_byte[6:0], 1'b0};
                sda_low_q <= !status_byte[7];
                state_q   <= LBSC_RDATA;
              end else begin
                sda_low_q <= 1'b0;
                state_q   <= LBSC_WDATA;
              end
            end
          end
          LBSC_WDATA: begin
            if (scl_rise) begin
              shift_q   <= {shift_q[6:0], sda_s};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && bit_cnt_q == 4'h8) begin
              // single-byte protocol: extra bytes are not acknowledged
              if (!data_done_q) begin
                wr_stb_q  <= 1'b1;
                sda_low_q <= 1'b1;
              end
              data_done_q <= 1'b1;
              state_q     <= LBSC_WACK;
            end
          end
          LBSC_WACK: begin
            if (scl_fall) begin
              sda_low_q <= 1'b0;
              bit_cnt_q <= 4'h0;
              state_q   <= LBSC_WDATA;
            end
          end
          LBSC_RDATA: begin
            if (scl_fall) begin
              bit_cnt_q <= bit_cnt_q + 4'h1;
              if (bit_cnt_q == 4'h7) begin
                sda_low_q <= 1'b0;
                state_q   <= LBSC_RACK;
              end else begin
                sda_low_q <= !shift_q[7];
                shift_q   <= {shift_q[6:0], 1'b0};
              end
            end
          end
          LBSC_RACK: begin
            if (scl_fall) begin
              state_q <= LBSC_IDLE;
            end
          end
        endcase
      end
    end
  end

  assign cfg.wr_stb  = wr_stb_q;
  assign cfg.wr_byte = shift_q;

  // open drain: output value fixed low, enable carries the drive
  assign smb_sda_out    = 1'b0;
  assign smb_sda_oe_out = sda_low_q;

  logic panel_on_q;
  logic run_q;
  logic [4:0] dac_q;
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      panel_on_q <= 1'b0;
      run_q      <= 1'b1;
      dac_q      <= LBSC_DAC_RESET;
    end else begin
      panel_on_q <= pg_s && panel_en;
      run_q      <= running;
      dac_q      <= cfg.dac_code;
    end
  end

  assign panel_switch_n_out    = 1'b0;
  assign panel_switch_n_oe_out = panel_on_q;
  assign shutdown_n_pin_out    = run_q;
  assign dac_code_out          = dac_q;

  // address phase ends in the acknowledge state
  sequence s_addr_taken;
    state_q == LBSC_ADDR ##1 state_q == LBSC_ADDR_ACK;
  endsequence
  // the fall that ends a read address ack loads the status byte
  sequence s_status_load;
    state_q == LBSC_ADDR_ACK && is_read_q && scl_fall;
  endsequence

  a_panel_gate: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    panel_switch_n_oe_out |-> $past(pg_s) && $past(panel_en))
    else $error("panel switch driven without power good and enable");
  a_panel_pg: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    !pg_s |=> !panel_switch_n_oe_out)
    else $error("panel switch driven while power not good");
  a_panel_on: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (pg_s && panel_en) |=> panel_switch_n_oe_out)
    else $error("panel switch not driven when enabled");
  a_status_pg: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    status_byte[7] == (pg_s && active_cfg[1]))
    else $error("status power good wrong");
  a_status_rsvd: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    s_status_load |=> shift_q[7:6] == LBSC_RSVD_BITS && shift_q[5:1] == $past(cfg.dac_code))
    else $error("status layout wrong");
  a_sel_keep: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (!cfg.wr_stb && $changed(sel_sync_q[1])) |=> $stable(cfg.dac_code))
    else $error("dac code changed on register switch");
  a_shutdown_n_pin_out: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    ##1 shutdown_n_pin_out == $past(running, 1))
    else $error("shutdown output not following active register");
  a_addr_match: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    s_addr_taken |-> $past(shift_q[7:1]) == LBSC_SLAVE_ADDR)
    else $error("acknowledged a foreign address");
endmodule

// file: testbench/lbsc_smb_host.sv
// smbus host model: drives the serial clock and pulls the data line low
`timescale 1ns/1ps
module lbsc_smb_host (
  // bus lines
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  // quarter of a 125 ns bit; the clock stands high between frames
  localparam realtime QTR = 31.25;
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  task automatic put_bit(input logic b);
    sda_oe_out = ~b;
    #QTR scl_out = 1'b1;
    #(2 * QTR) scl_out = 1'b0;
    #QTR;
  endtask
  task automatic get_bit(output logic b);
    sda_oe_out = 1'b0;
    #QTR scl_out = 1'b1;
    #QTR b = sda_in;
    #QTR scl_out = 1'b0;
    #QTR;
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack_n);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(ack_n);
  endtask
  task automatic start_cond();
    sda_oe_out = 1'b1;
    #QTR scl_out = 1'b0;
    #QTR;
  endtask
  task automatic stop_cond();
    sda_oe_out = 1'b1;
    #QTR scl_out = 1'b1;
    #QTR sda_oe_out = 1'b0;
    #QTR;
  endtask
  task automatic write_byte(input logic [6:0] addr, input logic [7:0] d,
                            output logic [1:0] acks_n);
    start_cond();
    put_byte({addr, 1'b0}, acks_n[1]);
    put_byte(d, acks_n[0]);
    stop_cond();
  endtask
  task automatic read_byte(input logic [6:0] addr, output logic [7:0] d,
                           output logic ack_n);
    start_cond();
    put_byte({addr, 1'b1}, ack_n);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(1'b1);
    stop_cond();
  endtask
endmodule

// file: testbench/lbsc_top_tb.sv
// self-checking bench for the lcd bias serial control block
`timescale 1ns/1ps
module lbsc_top_tb import lbsc_pkg::*;;
  logic       core_clk_in, rstn_in, pin, pg, scl, host_oe, dev_oe, sda_lvl, panel_oe, shutdown_n_pin_n;
  logic       sda_v, pnl_v;
  logic [4:0] dac, dac_exp;
  logic [1:0] run_cfg, stby_cfg, acks;
  logic [7:0] got, rd;
  logic [7:0] expq[$];
  logic [7:0] tbl[4] = '{8'h9F, 8'h60, 8'hA0, 8'h3F};
  event       got_ev;
  int         num_errors = 0;
  int         comparisons = 0;
  // pull-up on the data line; the device's pin value counts only while it drives
  assign sda_lvl = ~host_oe & (dev_oe ? sda_v : 1'b1);
  lbsc_top lbsc_top_inst (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .smb_scl_in(scl),
    .smb_sda_in(sda_lvl), .smb_sda_out(sda_v), .smb_sda_oe_out(dev_oe),
    .low_power_select_pin_in(pin), .power_good_sense_in(pg), .panel_switch_n_out(pnl_v),
    .panel_switch_n_oe_out(panel_oe), .shutdown_n_pin_out(shutdown_n_pin_n), .dac_code_out(dac));
  lbsc_smb_host lbsc_smb_host_inst (.sda_in(sda_lvl), .scl_out(scl), .sda_oe_out(host_oe));
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end
  always @(got_ev) begin
    comparisons++;
    if (expq.size() == 0 || got !== expq[0]) begin
      num_errors++;
      $display("[ERR] %0t got %h", $time, got);
    end
    if (expq.size() != 0) void'(expq.pop_front());
  end
  task automatic chk(input logic [7:0] e, input logic [7:0] a);
    expq.push_back(e);
    got = a;
    ->got_ev;
    #1;
  endtask
  task automatic check_all(input logic p, input logic g);
    logic [1:0] act;
    @(posedge core_clk_in) #1;
    pin = p;
    pg = g;
    repeat (8) @(posedge core_clk_in);
    act = p ? run_cfg : stby_cfg;
    chk({3'h0, dac_exp}, {3'h0, dac});
    chk({7'h0, act[1]}, {7'h0, shutdown_n_pin_n});
    chk({7'h0, g & act[0]}, {7'h0, panel_oe});
    chk(8'h00, {6'h0, pnl_v, sda_v});
    lbsc_smb_host_inst.read_byte(LBSC_SLAVE_ADDR, rd, acks[0]);
    chk(8'h00, {7'h0, acks[0]});
    chk({g & act[1], LBSC_RSVD_BITS, dac_exp}, rd);
  endtask
  task automatic wr(input logic [7:0] d);
    lbsc_smb_host_inst.write_byte(LBSC_SLAVE_ADDR, d, acks);
    chk(8'h00, {6'h0, acks});
    if (d[LBSC_SEL_BIT]) run_cfg = d[6:5];
    else stby_cfg = d[6:5];
    dac_exp = d[4:0];
  endtask
  task automatic do_reset();
    @(posedge core_clk_in) #1;
    rstn_in = 1'b0;
    run_cfg = LBSC_RUN_RESET;
    stby_cfg = LBSC_STBY_RESET;
    dac_exp = LBSC_DAC_RESET;
    repeat (16) @(posedge core_clk_in);
    #1 rstn_in = 1'b1;
    repeat (4) @(posedge core_clk_in);
  endtask
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    // about three and a half times what the whole sequence needs
    #400000;
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    rstn_in = 1'b0;
    pin = 1'b1;
    pg = 1'b1;
    void'($urandom(52072));
    do_reset();
    check_all(1'b1, 1'b1);
    check_all(1'b0, 1'b1);
    // neighbouring address must get neither ack
    lbsc_smb_host_inst.write_byte(LBSC_SLAVE_ADDR + 7'h01, 8'h01, acks);
    chk(8'h03, {6'h0, acks});
    check_all(1'b1, 1'b1);
    // a second data byte in one frame is neither acknowledged nor stored
    lbsc_smb_host_inst.start_cond();
    lbsc_smb_host_inst.put_byte({LBSC_SLAVE_ADDR, 1'b0}, acks[1]);
    lbsc_smb_host_inst.put_byte(8'h85, acks[0]);
    lbsc_smb_host_inst.put_byte(8'h1A, rd[0]);
    lbsc_smb_host_inst.stop_cond();
    chk(8'h00, {6'h0, acks});
    chk(8'h01, {7'h0, rd[0]});
    run_cfg = 2'h0;
    dac_exp = 5'h05;
    check_all(1'b1, 1'b1);
    foreach (tbl[i]) begin
      wr(tbl[i]);
      for (int k = 0; k < 4; k++) check_all(k[1], k[0]);
    end
    for (int i = 0; i < 8; i++) begin
      wr(8'($urandom));
      check_all(1'($urandom), 1'($urandom));
    end
    // second reset in mid-run restores power-up state
    // move every register away from its power-up value first
    wr(8'h80);
    wr(8'h7F);
    do_reset();
    check_all(1'b1, 1'b1);
    check_all(1'b0, 1'b1);
    tally_and_finish();
  end
endmodule
